// [inc/fwpc_map.svh]
// address decode, field positions, control bits and reset values of the cache
`ifndef FWPC_MAP_SVH
`define FWPC_MAP_SVH
`define FWPC_TAG_REGION  8'hf0
`define FWPC_DATA_REGION 8'hf1
`define FWPC_CTRL_ADDR   32'hf200_0000
`define FWPC_REGION_HI   31
`define FWPC_REGION_LO   24
`define FWPC_WAY_HI      13
`define FWPC_WAY_LO      12
`define FWPC_IDX_HI      11
`define FWPC_IDX_LO      4
`define FWPC_LINE_LO     4
`define FWPC_ASSOC_BIT   3
`define FWPC_WORD_HI     3
`define FWPC_WORD_LO     2
`define FWPC_ALIGN_HI    1
`define FWPC_ALIGN_LO    0
`define FWPC_ALIGN_OK    2'h0
`define FWPC_TAG_HI      31
`define FWPC_TAG_LO      10
`define FWPC_LRU_HI      9
`define FWPC_LRU_LO      4
`define FWPC_DIRTY_BIT   1
`define FWPC_VALID_BIT   0
`define FWPC_CTL_WAY2_LOCK  0
`define FWPC_CTL_WAY2_PREFETCH_LOAD  1
`define FWPC_CTL_WAY3_LOCK  8
`define FWPC_CTL_WAY3_PREFETCH_LOAD  9
`define FWPC_CTL_LOCKEN  16
`define FWPC_CTL_WTHRU   17
`define FWPC_CTL_WBFULL  24
`define FWPC_CTL_REFUSED 25
`define FWPC_LRU_RESET   6'h00
`define FWPC_LINE_WORDS  3'h4
`define FWPC_LAST_WORD   2'h3
`define FWPC_WAYS        4
`define FWPC_ENTRIES     256
`endif

// [inc/fwpc_pkg.sv]
// types shared by the cache modules
package fwpc_pkg;
	typedef enum logic [3:0] {
		FWPC_IDLE  = 4'h1,
		FWPC_LOOK  = 4'h2,
		FWPC_FILL  = 4'h4,
		FWPC_WRITE = 4'h8
	} fwpc_state_t;
	typedef enum logic [2:0] {
		FWPC_OWN_FILL = 3'h1,
		FWPC_OWN_WT   = 3'h2,
		FWPC_OWN_DRN  = 3'h4
	} fwpc_own_t;
	typedef enum logic [1:0] {
		FWPC_OP_READ  = 2'h0,
		FWPC_OP_PREF  = 2'h1,
		FWPC_OP_WRITE = 2'h2
	} fwpc_op_t;
endpackage

// [inc/fwpc_repl_if.sv]
// replacement-way request and answer between the cache and its way chooser
`timescale 1ns/1ps
interface fwpc_repl_if;
	logic [5:0] lru;
	logic       lock_en;
	logic       way3_prefetch_load;
	logic       way3_lock;
	logic       way2_prefetch_load;
	logic       way2_lock;
	logic       prefetch;
	logic [1:0] way;
	modport chooser (input lru, lock_en, way3_prefetch_load, way3_lock, way2_prefetch_load, way2_lock, prefetch, output way);
	modport user (output lru, lock_en, way3_prefetch_load, way3_lock, way2_prefetch_load, way2_lock, prefetch, input way);
endinterface

// [rtl/fwpc_repl.sv]
// way chooser: lru decode, restricted when ways are locked, forced on locked prefetch
`timescale 1ns/1ps
module fwpc_repl (
	fwpc_repl_if.chooser rp
);
	logic [3:0] cand;
	logic [3:0] oldest;
	logic [1:0] way_sel;

	// true when way a is older than way b in the six-bit pairwise order
	function automatic logic older(input logic [5:0] l, input logic [1:0] a, input logic [1:0] b);
		logic r;
		r = 1'b0;
		case ({a, b})
			4'h1: r = l[5];
			4'h2: r = l[4];
			4'h3: r = l[3];
			4'h6: r = l[2];
			4'h7: r = l[1];
			4'hb: r = l[0];
			4'h4: r = !l[5];
			4'h8: r = !l[4];
			4'hc: r = !l[3];
			4'h9: r = !l[2];
			4'hd: r = !l[1];
			4'he: r = !l[0];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// locked ways leave the candidate set, the oldest remaining one is chosen
	always_comb begin
		cand = 4'hf;
		if (rp.lock_en && rp.way3_lock) cand[3] = 1'b0;
		if (rp.lock_en && rp.way2_lock) cand[2] = 1'b0;
		for (int w = 0; w < 4; w++) begin
			oldest[w] = cand[w];
			for (int v = 0; v < 4; v++) begin
				if (v != w && cand[v] && !older(rp.lru, 2'(w), 2'(v))) oldest[w] = 1'b0;
			end
		end
		way_sel = 2'h0;
		for (int w = 3; w >= 0; w--) begin
			if (cand[w]) way_sel = 2'(w);
		end
		for (int w = 3; w >= 0; w--) begin
			if (oldest[w]) way_sel = 2'(w);
		end
		if (rp.prefetch && rp.lock_en) begin
			if (rp.way3_prefetch_load && rp.way3_lock) way_sel = 2'h3;
			else if (rp.way2_prefetch_load && rp.way2_lock) way_sel = 2'h2;
		end
	end

	assign rp.way = way_sel;
endmodule

// [rtl/fwpc_cache.sv]
// four-way physically tagged cache with write-back buffer and memory-mapped arrays
//
// Functional notes
// - index from virtual bits 11..4, parallel translation
// - hit needs tag match and valid set
// - read hit returns word, updates lru
// - read miss refills line, forwards missed word
// - refilled line: valid set, dirty set only after a write miss
// - prefetch hit only makes way newest
// - prefetch miss refills, returns nothing
// - write-back hit: cache only, dirty set
// - write-through hit: cache and memory written
// - write-back miss allocates, dirty victim buffered
// - write-through miss writes memory only
// - fill before drain; cache usable while draining
// - buffer holds one line and address
// - tag array f0, data array f1, words
// - tag access decodes index, way, associative bit
// - tag word: tag, lru, dirty, valid
// - tag read never associative
// - plain tag write, dirty line written back
// - associative write updates flags of hit way
// - associative hit on dirty line written back
// - data access decodes index, way, word
// - locked prefetch forces way three or two
// - locked ways excluded from ordinary replacement
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "fwpc_map.svh"
module fwpc_cache (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        cpu_req_i,
	input  wire logic [1:0]  cpu_op_i,
	input  wire logic [31:0] cpu_vaddr_i,
	input  wire logic [31:0] cpu_paddr_i,
	input  wire logic [31:0] cpu_wdata_i,
	output logic             cpu_ready_o,
	output logic             cpu_done_o,
	output logic [31:0]      cpu_rdata_o,
	input  wire logic [31:0] reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic [31:0]      reg_rdata_o,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic [31:0]      mem_addr_o,
	output logic [31:0]      mem_wdata_o,
	input  wire logic        mem_ack_i,
	input  wire logic [31:0] mem_rdata_i
);
	typedef logic [`FWPC_TAG_HI:`FWPC_TAG_LO] fwpc_tag_t;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	fwpc_tag_t   tag_ff   [`FWPC_WAYS][`FWPC_ENTRIES];
	logic        valid_ff [`FWPC_WAYS][`FWPC_ENTRIES];
	logic        dirty_ff [`FWPC_WAYS][`FWPC_ENTRIES];
	logic [5:0]  lru_ff   [`FWPC_ENTRIES];
	logic [31:0] data_ff  [`FWPC_WAYS][`FWPC_ENTRIES][4];

	fwpc_pkg::fwpc_state_t state_ff;
	fwpc_pkg::fwpc_state_t nxt_state;
	fwpc_pkg::fwpc_own_t   own_ff;
	logic [1:0]  req_op_ff;
	logic [7:0]  req_idx_ff;
	logic [31:2] req_pa_ff;
	logic [31:0] req_wdata_ff;
	logic [1:0]  vic_ff;
	logic [2:0]  fill_cnt_ff;
	logic        wb_full_ff;
	logic [27:0] wb_line_ff;
	logic [31:0] wb_data_ff [4];
	logic [1:0]  drn_cnt_ff;
	logic        lock_en_ff, way3_prefetch_load_ff, way3_lock_ff, way2_prefetch_load_ff, way2_lock_ff, wthru_ff, refused_ff;
	logic        cpu_ready_ff, cpu_done_ff, mem_req_ff, mem_we_ff;
	logic [31:0] cpu_rdata_ff, reg_rdata_ff, mem_addr_ff, mem_wdata_ff;

	fwpc_repl_if rp ();

	fwpc_repl u_repl (
		.rp (rp)
	);

	// makes way w the newest of the entry
	function automatic logic [5:0] lru_touch(input logic [5:0] l, input logic [1:0] w);
		logic [5:0] r;
		r = l;
		case (w)
			2'h0: r[5:3] = 3'h0;
			2'h1: begin
				r[5] = 1'b1;
				r[2:1] = 2'h0;
			end
			2'h2: begin
				r[4] = 1'b1;
				r[2] = 1'b1;
				r[0] = 1'b0;
			end
			default: begin
				r[3] = 1'b1;
				r[1] = 1'b1;
				r[0] = 1'b1;
			end
		endcase
		return r;
	endfunction

	// tag compare across all ways of one entry, answers hit and hit way
	function automatic logic [2:0] match(input logic [7:0] idx, input fwpc_tag_t t);
		logic [2:0] r;
		r = 3'h0;
		for (int w = 0; w < `FWPC_WAYS; w++) begin
			if (valid_ff[w][idx] && tag_ff[w][idx] == t) r = {1'b1, 2'(w)};
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// lookup of the latched request
	// ----------------------------------------------------------------
	logic [2:0] look_m;
	logic       is_wr, is_rd, alloc, vic_wb, ld_look, fill_end, ack_fill, ack_wt, ack_drn;
	logic [1:0] hw, vic, fill_ptr;
	fwpc_tag_t  req_tag;

	assign req_tag  = req_pa_ff[`FWPC_TAG_HI:`FWPC_TAG_LO];
	assign look_m   = match(req_idx_ff, req_tag);
	assign hw       = look_m[1:0];
	assign is_wr    = req_op_ff == fwpc_pkg::FWPC_OP_WRITE;
	assign is_rd    = req_op_ff == fwpc_pkg::FWPC_OP_READ;
	assign alloc    = !(is_wr && wthru_ff);
	assign vic      = rp.way;
	assign vic_wb   = valid_ff[vic][req_idx_ff] && dirty_ff[vic][req_idx_ff];
	assign ld_look  = state_ff == fwpc_pkg::FWPC_LOOK && !look_m[2] && alloc && vic_wb
		&& !wb_full_ff;
	assign fill_end = state_ff == fwpc_pkg::FWPC_FILL && fill_cnt_ff == `FWPC_LINE_WORDS;
	assign fill_ptr = req_pa_ff[`FWPC_WORD_HI:`FWPC_WORD_LO] + fill_cnt_ff[1:0];
	assign ack_fill = mem_req_ff && mem_ack_i && own_ff == fwpc_pkg::FWPC_OWN_FILL;
	assign ack_wt   = mem_req_ff && mem_ack_i && own_ff == fwpc_pkg::FWPC_OWN_WT;
	assign ack_drn  = mem_req_ff && mem_ack_i && own_ff == fwpc_pkg::FWPC_OWN_DRN;

	// way chooser inputs
	assign rp.lru      = lru_ff[req_idx_ff];
	assign rp.lock_en  = lock_en_ff;
	assign rp.way3_prefetch_load   = way3_prefetch_load_ff;
	assign rp.way3_lock   = way3_lock_ff;
	assign rp.way2_prefetch_load   = way2_prefetch_load_ff;
	assign rp.way2_lock   = way2_lock_ff;
	assign rp.prefetch = req_op_ff == fwpc_pkg::FWPC_OP_PREF;

	// ----------------------------------------------------------------
	// register port decode
	// ----------------------------------------------------------------
	logic [7:0] r_idx;
	logic [1:0] r_way, r_word, r_wbway;
	logic [2:0] r_m;
	logic       r_aligned, r_tag, r_data, r_ctrl, r_assoc, r_needwb, r_refuse, ld_reg, r_apply;

	assign r_idx     = reg_addr_i[`FWPC_IDX_HI:`FWPC_IDX_LO];
	assign r_way     = reg_addr_i[`FWPC_WAY_HI:`FWPC_WAY_LO];
	assign r_word    = reg_addr_i[`FWPC_WORD_HI:`FWPC_WORD_LO];
	assign r_aligned = reg_addr_i[`FWPC_ALIGN_HI:`FWPC_ALIGN_LO] == `FWPC_ALIGN_OK;
	assign r_tag     = reg_addr_i[`FWPC_REGION_HI:`FWPC_REGION_LO] == `FWPC_TAG_REGION
		&& r_aligned;
	assign r_data    = reg_addr_i[`FWPC_REGION_HI:`FWPC_REGION_LO] == `FWPC_DATA_REGION
		&& r_aligned;
	assign r_ctrl    = reg_addr_i == `FWPC_CTRL_ADDR;
	assign r_assoc   = reg_addr_i[`FWPC_ASSOC_BIT];
	assign r_m       = match(r_idx, reg_wdata_i[`FWPC_TAG_HI:`FWPC_TAG_LO]);
	assign r_wbway   = r_assoc ? r_m[1:0] : r_way;
	// a dirty line about to be overwritten goes out through the buffer first
	assign r_needwb  = r_assoc ? (r_m[2] && dirty_ff[r_m[1:0]][r_idx])
		: (valid_ff[r_way][r_idx] && dirty_ff[r_way][r_idx]);
	assign r_refuse  = reg_we_i && r_tag && r_needwb && (wb_full_ff || ld_look);
	assign ld_reg    = reg_we_i && r_tag && r_needwb && !r_refuse;
	assign r_apply   = reg_we_i && r_tag && !r_refuse;

	// ----------------------------------------------------------------
	// request sequencing
	// ----------------------------------------------------------------
	// next state of the request sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			fwpc_pkg::FWPC_IDLE: begin
				if (cpu_req_i) nxt_state = fwpc_pkg::FWPC_LOOK;
			end
			fwpc_pkg::FWPC_LOOK: begin
				if (is_wr && wthru_ff) nxt_state = fwpc_pkg::FWPC_WRITE;
				else if (look_m[2]) nxt_state = fwpc_pkg::FWPC_IDLE;
				else if (vic_wb && wb_full_ff) nxt_state = fwpc_pkg::FWPC_LOOK;
				else nxt_state = fwpc_pkg::FWPC_FILL;
			end
			fwpc_pkg::FWPC_FILL: begin
				if (fill_end) nxt_state = fwpc_pkg::FWPC_IDLE;
			end
			fwpc_pkg::FWPC_WRITE: begin
				if (ack_wt) nxt_state = fwpc_pkg::FWPC_IDLE;
			end
			default: nxt_state = fwpc_pkg::FWPC_IDLE;
		endcase
	end

	// state register and ready flag
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_ff     <= fwpc_pkg::FWPC_IDLE;
			cpu_ready_ff <= 1'b1;
		end else begin
			state_ff     <= nxt_state;
			cpu_ready_ff <= nxt_state == fwpc_pkg::FWPC_IDLE;
		end
	end

	// latch the request and the victim way
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			req_op_ff    <= fwpc_pkg::FWPC_OP_READ;
			req_idx_ff   <= '0;
			req_pa_ff    <= '0;
			req_wdata_ff <= '0;
			vic_ff       <= '0;
		end else begin
			if (state_ff == fwpc_pkg::FWPC_IDLE && cpu_req_i) begin
				req_op_ff    <= cpu_op_i;
				req_idx_ff   <= cpu_vaddr_i[`FWPC_IDX_HI:`FWPC_IDX_LO];
				req_pa_ff    <= cpu_paddr_i[31:2];
				req_wdata_ff <= cpu_wdata_i;
			end
			if (state_ff == fwpc_pkg::FWPC_LOOK) vic_ff <= vic;
		end
	end

	// answers to the cpu
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cpu_done_ff  <= 1'b0;
			cpu_rdata_ff <= '0;
		end else begin
			cpu_done_ff <= 1'b0;
			if (state_ff == fwpc_pkg::FWPC_LOOK && look_m[2] && !(is_wr && wthru_ff)) begin
				cpu_done_ff <= 1'b1;
				if (is_rd) cpu_rdata_ff <= data_ff[hw][req_idx_ff][req_pa_ff[3:2]];
			end
			if (ack_fill && fill_cnt_ff == 3'h0 && is_rd) begin
				cpu_done_ff  <= 1'b1;
				cpu_rdata_ff <= mem_rdata_i;
			end
			if (fill_end && !is_rd) cpu_done_ff <= 1'b1;
			if (ack_wt) cpu_done_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// tag, flag, lru and data arrays
	// ----------------------------------------------------------------
	// all array updates; register port writes come last and win
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			for (int e = 0; e < `FWPC_ENTRIES; e++) begin
				lru_ff[e] <= `FWPC_LRU_RESET;
				for (int w = 0; w < `FWPC_WAYS; w++) begin
					valid_ff[w][e] <= 1'b0;
					dirty_ff[w][e] <= 1'b0;
				end
			end
		end else begin
			if (state_ff == fwpc_pkg::FWPC_LOOK && look_m[2]) begin
				lru_ff[req_idx_ff] <= lru_touch(lru_ff[req_idx_ff], hw);
				if (is_wr) begin
					data_ff[hw][req_idx_ff][req_pa_ff[3:2]] <= req_wdata_ff;
					if (!wthru_ff) dirty_ff[hw][req_idx_ff] <= 1'b1;
				end
			end
			if (state_ff == fwpc_pkg::FWPC_LOOK && !look_m[2] && alloc
				&& !(vic_wb && wb_full_ff)) begin
				tag_ff[vic][req_idx_ff]   <= req_tag;
				valid_ff[vic][req_idx_ff] <= 1'b0;
				dirty_ff[vic][req_idx_ff] <= 1'b0;
			end
			if (ack_fill) data_ff[vic_ff][req_idx_ff][fill_ptr] <= mem_rdata_i;
			if (fill_end) begin
				valid_ff[vic_ff][req_idx_ff] <= 1'b1;
				dirty_ff[vic_ff][req_idx_ff] <= is_wr;
				lru_ff[req_idx_ff]           <= lru_touch(lru_ff[req_idx_ff], vic_ff);
				if (is_wr) data_ff[vic_ff][req_idx_ff][req_pa_ff[3:2]] <= req_wdata_ff;
			end
			if (r_apply && !r_assoc) begin
				tag_ff[r_way][r_idx]   <= reg_wdata_i[`FWPC_TAG_HI:`FWPC_TAG_LO];
				lru_ff[r_idx]          <= reg_wdata_i[`FWPC_LRU_HI:`FWPC_LRU_LO];
				dirty_ff[r_way][r_idx] <= reg_wdata_i[`FWPC_DIRTY_BIT];
				valid_ff[r_way][r_idx] <= reg_wdata_i[`FWPC_VALID_BIT];
			end
			if (r_apply && r_assoc && r_m[2]) begin
				dirty_ff[r_m[1:0]][r_idx] <= reg_wdata_i[`FWPC_DIRTY_BIT];
				valid_ff[r_m[1:0]][r_idx] <= reg_wdata_i[`FWPC_VALID_BIT];
			end
			if (reg_we_i && r_data) data_ff[r_way][r_idx][r_word] <= reg_wdata_i;
		end
	end

	// ----------------------------------------------------------------
	// write-back buffer
	// ----------------------------------------------------------------
	// one line plus its address, loaded by a miss or a tag write, emptied by draining
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wb_full_ff <= 1'b0;
			drn_cnt_ff <= '0;
			wb_line_ff <= '0;
		end else if (ld_look) begin
			wb_full_ff <= 1'b1;
			drn_cnt_ff <= '0;
			wb_line_ff <= {tag_ff[vic][req_idx_ff], req_idx_ff[5:0]};
			for (int i = 0; i < 4; i++) wb_data_ff[i] <= data_ff[vic][req_idx_ff][i];
		end else if (ld_reg) begin
			wb_full_ff <= 1'b1;
			drn_cnt_ff <= '0;
			wb_line_ff <= {tag_ff[r_wbway][r_idx], r_idx[5:0]};
			for (int i = 0; i < 4; i++) wb_data_ff[i] <= data_ff[r_wbway][r_idx][i];
		end else if (ack_drn) begin
			drn_cnt_ff <= drn_cnt_ff + 2'h1;
			if (drn_cnt_ff == `FWPC_LAST_WORD) wb_full_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// memory bus master
	// ----------------------------------------------------------------
	// refill words count up; the finishing cycle clears the count
	always_ff @(posedge clock_i) begin
		if (rst_i) fill_cnt_ff <= '0;
		else if (fill_end) fill_cnt_ff <= '0;
		else if (ack_fill) fill_cnt_ff <= fill_cnt_ff + 3'h1;
	end

	// one word per request; fill and write-through beat draining between words
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mem_req_ff   <= 1'b0;
			mem_we_ff    <= 1'b0;
			mem_addr_ff  <= '0;
			mem_wdata_ff <= '0;
			own_ff       <= fwpc_pkg::FWPC_OWN_FILL;
		end else if (mem_req_ff) begin
			if (mem_ack_i) mem_req_ff <= 1'b0;
		end else if (state_ff == fwpc_pkg::FWPC_FILL && fill_cnt_ff != `FWPC_LINE_WORDS) begin
			mem_req_ff  <= 1'b1;
			mem_we_ff   <= 1'b0;
			mem_addr_ff <= {req_tag, req_idx_ff[5:0], fill_ptr, `FWPC_ALIGN_OK};
			own_ff      <= fwpc_pkg::FWPC_OWN_FILL;
		end else if (state_ff == fwpc_pkg::FWPC_WRITE) begin
			mem_req_ff   <= 1'b1;
			mem_we_ff    <= 1'b1;
			mem_addr_ff  <= {req_pa_ff, `FWPC_ALIGN_OK};
			mem_wdata_ff <= req_wdata_ff;
			own_ff       <= fwpc_pkg::FWPC_OWN_WT;
		end else if (wb_full_ff && state_ff != fwpc_pkg::FWPC_FILL) begin
			mem_req_ff   <= 1'b1;
			mem_we_ff    <= 1'b1;
			mem_addr_ff  <= {wb_line_ff, drn_cnt_ff, `FWPC_ALIGN_OK};
			mem_wdata_ff <= wb_data_ff[drn_cnt_ff];
			own_ff       <= fwpc_pkg::FWPC_OWN_DRN;
		end
	end

	// ----------------------------------------------------------------
	// control register and register reads
	// ----------------------------------------------------------------
	// lock, policy bits and refusal flag; a new refusal beats its clear
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			{lock_en_ff, way3_prefetch_load_ff, way3_lock_ff, way2_prefetch_load_ff, way2_lock_ff} <= '0;
			wthru_ff   <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			if (reg_we_i && r_ctrl) begin
				lock_en_ff <= reg_wdata_i[`FWPC_CTL_LOCKEN];
				way3_prefetch_load_ff  <= reg_wdata_i[`FWPC_CTL_WAY3_PREFETCH_LOAD];
				way3_lock_ff  <= reg_wdata_i[`FWPC_CTL_WAY3_LOCK];
				way2_prefetch_load_ff  <= reg_wdata_i[`FWPC_CTL_WAY2_PREFETCH_LOAD];
				way2_lock_ff  <= reg_wdata_i[`FWPC_CTL_WAY2_LOCK];
				wthru_ff   <= reg_wdata_i[`FWPC_CTL_WTHRU];
				if (reg_wdata_i[`FWPC_CTL_REFUSED]) refused_ff <= 1'b0;
			end
			if (r_refuse) refused_ff <= 1'b1;
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			reg_rdata_ff <= '0;
		end else begin
			reg_rdata_ff <= '0;
			if (reg_re_i && r_tag) begin
				reg_rdata_ff[`FWPC_TAG_HI:`FWPC_TAG_LO] <= tag_ff[r_way][r_idx];
				reg_rdata_ff[`FWPC_LRU_HI:`FWPC_LRU_LO] <= lru_ff[r_idx];
				reg_rdata_ff[`FWPC_DIRTY_BIT]           <= dirty_ff[r_way][r_idx];
				reg_rdata_ff[`FWPC_VALID_BIT]           <= valid_ff[r_way][r_idx];
			end else if (reg_re_i && r_data) begin
				reg_rdata_ff <= data_ff[r_way][r_idx][r_word];
			end else if (reg_re_i && r_ctrl) begin
				reg_rdata_ff[`FWPC_CTL_LOCKEN]  <= lock_en_ff;
				reg_rdata_ff[`FWPC_CTL_WAY3_PREFETCH_LOAD]  <= way3_prefetch_load_ff;
				reg_rdata_ff[`FWPC_CTL_WAY3_LOCK]  <= way3_lock_ff;
				reg_rdata_ff[`FWPC_CTL_WAY2_PREFETCH_LOAD]  <= way2_prefetch_load_ff;
				reg_rdata_ff[`FWPC_CTL_WAY2_LOCK]  <= way2_lock_ff;
				reg_rdata_ff[`FWPC_CTL_WTHRU]   <= wthru_ff;
				reg_rdata_ff[`FWPC_CTL_WBFULL]  <= wb_full_ff;
				reg_rdata_ff[`FWPC_CTL_REFUSED] <= refused_ff;
			end
		end
	end

	// outputs straight from flip-flops
	assign cpu_ready_o = cpu_ready_ff;
	assign cpu_done_o  = cpu_done_ff;
	assign cpu_rdata_o = cpu_rdata_ff;
	assign reg_rdata_o = reg_rdata_ff;
	assign mem_req_o   = mem_req_ff;
	assign mem_we_o    = mem_we_ff;
	assign mem_addr_o  = mem_addr_ff;
	assign mem_wdata_o = mem_wdata_ff;
endmodule

// [tb/fwpc_cache_asserts.sv]
// concurrent checks on the cache top-level ports
`timescale 1ns/1ps
module fwpc_cache_asserts (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        cpu_req_i,
	input wire logic        cpu_ready_o,
	input wire logic        cpu_done_o,
	input wire logic [31:0] cpu_rdata_o,
	input wire logic        reg_re_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        mem_req_o,
	input wire logic        mem_we_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic        mem_ack_i,
	input wire logic [31:0] mem_rdata_i
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic [31:0] ack_addr_ff;
	logic        ack_we_ff;
	// address and direction of the last acknowledged memory word
	always_ff @(posedge clock_i) begin
		if (mem_ack_i) begin
			ack_addr_ff <= mem_addr_o;
			ack_we_ff   <= mem_we_o;
		end
	end
	a_done_pulse: assert property (cpu_done_o |=> !cpu_done_o) else $error("done too long");
	a_take_busy: assert property (cpu_req_i && cpu_ready_o |=> !cpu_ready_o && !cpu_done_o)
		else $error("request not taken");
	a_answer_bound: assert property (cpu_req_i && cpu_ready_o |-> ##[1:1000] cpu_done_o)
		else $error("request never answered");
	a_miss_word: assert property (cpu_done_o && !cpu_ready_o && $past(mem_ack_i)
		&& !$past(mem_we_o) |-> cpu_rdata_o == $past(mem_rdata_i)) else $error("word not passed");
	a_reg_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside its cycle");
	a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
		&& $stable(mem_we_o) && $stable(mem_wdata_o)) else $error("memory request moved");
	a_req_release: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("request kept after ack");
	a_fill_wrap: assert property ($rose(mem_req_o) && !mem_we_o && $past(mem_ack_i, 2)
		&& !ack_we_ff |-> mem_addr_o == {ack_addr_ff[31:4], ack_addr_ff[3:2] + 2'h1, 2'h0})
		else $error("fill word out of order");
endmodule
bind fwpc_cache fwpc_cache_asserts fwpc_cache_asserts_i (.clock_i, .rst_i, .cpu_req_i,
	.cpu_ready_o, .cpu_done_o, .cpu_rdata_o, .reg_re_i, .reg_rdata_o, .mem_req_o, .mem_we_o,
	.mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i);

// [tb/fwpc_mem_model.sv]
// external memory: acknowledges each word after a short or long wait
`timescale 1ns/1ps
module fwpc_mem_model (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        req_i,
	input  wire logic [31:0] addr_i,
	input  wire logic        slow_i,
	output logic             ack_o,
	output logic [31:0]      rdata_o
);
	logic [2:0] wait_ff;
	// count wait cycles, then give a one-cycle acknowledge
	always_ff @(posedge clock_i) begin
		if (rst_i || !req_i || ack_o) begin
			wait_ff <= 3'h0;
			ack_o   <= 1'b0;
		end else begin
			wait_ff <= wait_ff + 3'h1;
			ack_o   <= wait_ff >= (slow_i ? 3'h5 : 3'h0);
		end
	end
	// word pattern from the address, inverted outside the acknowledge cycle
	assign rdata_o = ack_o ? addr_i ^ 32'h5a5a_a5a5 : ~(addr_i ^ 32'h5a5a_a5a5);
endmodule

// [tb/test_four_way_physical_cache.sv]
// self-checking bench: cpu requests, array accesses and memory words
`timescale 1ns/1ps
`include "fwpc_map.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module test_four_way_physical_cache;
	localparam logic [31:0] pat = 32'h5a5a_a5a5;
	localparam logic [31:0] addr_a = 32'h0000_1238;
	localparam logic [31:0] addr_b = 32'h0000_5238;
	logic        clock_i, rst_i, cpu_req, reg_we, reg_re, slow, cpu_ready, cpu_done;
	logic        mem_req, mem_we, mem_ack;
	logic [1:0]  cpu_op;
	logic [31:0] cpu_vaddr, cpu_wdata, reg_addr, reg_wdata, got, cgot, tagw, waddr, wdata;
	logic [31:0] cpu_rdata, reg_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [31:0] wmem [4];
	int          err_count = 0, num_checks = 0, rcnt = 0, wcnt = 0, w, nv;
	fwpc_cache fwpc_cache_i (
		.clock_i(clock_i), .rst_i(rst_i), .cpu_req_i(cpu_req), .cpu_op_i(cpu_op),
		.cpu_vaddr_i(cpu_vaddr), .cpu_paddr_i(cpu_vaddr), .cpu_wdata_i(cpu_wdata),
		.cpu_ready_o(cpu_ready), .cpu_done_o(cpu_done), .cpu_rdata_o(cpu_rdata),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
		.reg_rdata_o(reg_rdata), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
		.mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata)
	);
	fwpc_mem_model fwpc_mem_model_i (
		.clock_i(clock_i), .rst_i(rst_i), .req_i(mem_req), .addr_i(mem_addr), .slow_i(slow),
		.ack_o(mem_ack), .rdata_o(mem_rdata)
	);
	// 25 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	// count memory words and keep the written ones
	always @(posedge clock_i) begin
		if (mem_req && mem_ack && !mem_we) rcnt++;
		if (mem_req && mem_ack && mem_we) begin
			wcnt++;
			waddr = mem_addr;
			wdata = mem_wdata;
			wmem[mem_addr[3:2]] = mem_wdata;
		end
	end
	task automatic wr(input logic [31:0] a, d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clock_i);
		reg_we <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [31:0] a);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clock_i);
		reg_re <= 1'b0;
		#1 got = reg_rdata;
		@(posedge clock_i);
	endtask
	// one cpu request, waits for the answer and for ready
	task automatic cpu(input logic [1:0] op, input logic [31:0] a, d);
		int n;
		cpu_op <= op;
		cpu_vaddr <= a;
		cpu_wdata <= d;
		cpu_req <= 1'b1;
		@(posedge clock_i);
		cpu_req <= 1'b0;
		n = 0;
		do begin
			@(posedge clock_i);
			#1 n++;
			if (cpu_done === 1'b1) cgot = cpu_rdata;
		end while (cpu_ready !== 1'b1 && n < 1000);
		if (n >= 1000) err_count++;
		@(posedge clock_i);
	endtask
	// tag reads of all ways with the associative bit set; counts valid ways
	task automatic tags(input logic [31:0] a);
		nv = 0;
		for (int i = 0; i < 4; i++) begin
			rd({8'hf0, 10'h0, i[1:0], a[11:4], 4'h8});
			if (got[0] === 1'b1) begin
				nv++;
				w = i;
				tagw = got;
			end
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clock_i);
		err_count++;
		results();
	end
	initial begin
		{rst_i, cpu_req, cpu_op, cpu_vaddr, cpu_wdata} = {1'b1, 67'h0};
		{reg_we, reg_re, reg_addr, reg_wdata, slow} = 67'h0;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		tags(addr_a);
		`CHK("valid after reset", 0, nv)
		cpu(fwpc_pkg::FWPC_OP_READ, addr_a, 32'h0);
		`CHK("miss word", addr_a ^ pat, cgot)
		`CHK("fill words", 4, rcnt)
		cgot = 32'h0;
		cpu(fwpc_pkg::FWPC_OP_READ, addr_a, 32'h0);
		`CHK("hit word", addr_a ^ pat, cgot)
		`CHK("hit reads", 4, rcnt)
		tags(addr_a);
		`CHK("valid ways", 1, nv)
		`CHK("tag field", addr_a[31:10], tagw[31:10])
		`CHK("dirty after fill", 1'b0, tagw[1])
		rd({8'hf1, 10'h0, w[1:0], addr_a[11:4], 4'h4});
		`CHK("array word 1", {addr_a[31:4], 4'h4} ^ pat, got)
		cpu(fwpc_pkg::FWPC_OP_WRITE, addr_a, 32'hdead_beef);
		`CHK("wb hit writes", 0, wcnt)
		rd({8'hf1, 10'h0, w[1:0], addr_a[11:4], 4'h8});
		`CHK("array word 2", 32'hdead_beef, got)
		tags(addr_a);
		`CHK("dirty after write", 1'b1, tagw[1])
		cpu(fwpc_pkg::FWPC_OP_PREF, addr_a, 32'h0);
		`CHK("pref hit reads", 4, rcnt)
		wr({8'hf0, 10'h0, 2'h0, addr_a[11:4], 4'h8}, {addr_a[31:10], 10'h0});
		for (int k = 0; k < 200 && wcnt < 4; k++) @(posedge clock_i);
		`CHK("drain words", 4, wcnt)
		`CHK("drain line", addr_a[31:4], waddr[31:4])
		`CHK("drain data", 32'hdead_beef, wmem[2])
		tags(addr_a);
		`CHK("invalidated", 0, nv)
		cpu(fwpc_pkg::FWPC_OP_PREF, addr_a - 32'h4, 32'h0);
		`CHK("pref fill", 8, rcnt)
		`CHK("pref no data", addr_a ^ pat, cpu_rdata)
		slow <= 1'b1;
		wr(`FWPC_CTRL_ADDR, 32'h1 << `FWPC_CTL_WTHRU);
		cpu(fwpc_pkg::FWPC_OP_WRITE, addr_a, 32'h1234_5678);
		`CHK("wt hit write", 5, wcnt)
		`CHK("wt hit addr", addr_a, waddr)
		`CHK("wt hit data", 32'h1234_5678, wdata)
		cpu(fwpc_pkg::FWPC_OP_READ, addr_a, 32'h0);
		`CHK("wt cached", 32'h1234_5678, cgot)
		cpu(fwpc_pkg::FWPC_OP_WRITE, addr_b, 32'h0bad_cafe);
		`CHK("wt miss write", 6, wcnt)
		`CHK("wt miss addr", addr_b, waddr)
		`CHK("wt miss reads", 8, rcnt)
		tags(addr_a);
		`CHK("no allocation", 1, nv)
		wr(`FWPC_CTRL_ADDR, 32'h0003_0103);
		cpu(fwpc_pkg::FWPC_OP_PREF, 32'h2448, 32'h0);
		tags(32'h2448);
		`CHK("lock pref way", 2, w)
		cpu(fwpc_pkg::FWPC_OP_READ, 32'h6448, 32'h0);
		tags(32'h2448);
		`CHK("lock way kept", 22'h9, tagw[31:10])
		wr(`FWPC_CTRL_ADDR, 32'h0);
		cpu(fwpc_pkg::FWPC_OP_WRITE, 32'ha448, 32'h600d_f00d);
		cpu(fwpc_pkg::FWPC_OP_READ, 32'ha448, 32'h0);
		`CHK("wb miss alloc", 32'h600d_f00d, cgot)
		rd(32'hf300_0000);
		`CHK("unmapped read", 32'h0, got)
		results();
	end
endmodule
